// [rtl/bls_params.svh]
`ifndef BLS_PARAMS_SVH
`define BLS_PARAMS_SVH

// ****************************************************************
// Register port map (8-bit address).
// ****************************************************************
`define BLS_GPR_BASE     8'h00
`define BLS_IO_BASE      8'h20
`define BLS_STATUS_ADDR  8'h40
`define BLS_STATUS_RESET 8'h00

// ****************************************************************
// Status register bit positions.
// ****************************************************************
`define BLS_FLAG_C 3'h0
`define BLS_FLAG_Z 3'h1
`define BLS_FLAG_N 3'h2
`define BLS_FLAG_V 3'h3
`define BLS_FLAG_S 3'h4
`define BLS_FLAG_H 3'h5
`define BLS_FLAG_T 3'h6
`define BLS_FLAG_I 3'h7

// ****************************************************************
// Pointer pair low registers and execution lengths in cycles.
// ****************************************************************
`define BLS_PTR_X_LO   5'h1A
`define BLS_PTR_Y_LO   5'h1C
`define BLS_PTR_Z_LO   5'h1E
`define BLS_SHORT_CYCLES 1
`define BLS_LONG_CYCLES  2

`endif

// [rtl/bls_pkg.sv]
package bls_pkg;

    typedef enum logic [4:0] {
        nop_op,
        io_bit_set_op,
        io_bit_clear_op,
        logic_shift_left_op,
        logic_shift_right_op,
        rotate_left_carry_op,
        rotate_right_carry_op,
        arith_shift_right_op,
        nibble_swap_op,
        bit_to_transfer_op,
        transfer_to_bit_op,
        flag_set_op,
        flag_clear_op,
        half_carry_set_op,
        half_carry_clear_op,
        overflow_set_op,
        overflow_clear_op,
        sign_test_set_op,
        sign_test_clear_op,
        register_copy_op,
        register_pair_copy_op,
        immediate_load_op,
        indirect_load_op,
        offset_load_op,
        absolute_load_op,
        indirect_store_op,
        offset_store_op,
        absolute_store_op
    } op_t;

    typedef enum logic [1:0] {
        ptr_x,
        ptr_y,
        ptr_z
    } ptr_t;

    typedef enum logic [1:0] {
        mode_plain,
        mode_post_inc,
        mode_pre_dec
    } amode_t;

    typedef struct packed {
        op_t         op;
        logic [4:0]  rd;
        logic [4:0]  rr;
        logic [2:0]  bitsel;
        logic [7:0]  imm;
        ptr_t        ptr;
        amode_t      amode;
        logic [5:0]  disp;
        logic [15:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
    } shift_t;

endpackage : bls_pkg

// [rtl/bls_data_mem.sv]
`timescale 1ns/1ps

module bls_data_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input  wire logic          i_clk,   // Core clock.
    input  wire logic          i_we,    // Write enable.
    input  wire logic [AW-1:0] i_addr,  // Word address.
    input  wire logic [DW-1:0] i_wdata, // Write data.
    output logic      [DW-1:0] o_rdata  // Registered read data.
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule : bls_data_mem

// [rtl/bit_and_load_store_exec.sv]
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "bls_params.svh"

// Functional notes
// - I/O bit set, flags kept, two cycles.
// - I/O bit clear, flags kept, two cycles.
// - Rotate left through carry, flags, one cycle.
// - Rotate right through carry, flags, one cycle.
// - Register bit copied to transfer flag only.
// - Transfer flag written into register bit.
// - Half-carry set, one cycle, alone.
// - Half-carry clear, one cycle, alone.
// - Overflow set, one cycle, alone.
// - Overflow clear, one cycle, alone.
// - Sign-test set and clear, one cycle.
// - Load then pointer increment, two cycles.
// - Pointer decrement then load, two cycles.
// - Displacement load, upper pointers, pointer kept.
// - Absolute address load, two cycles.
// - Store then pointer increment, two cycles.
// - Pointer decrement then store, two cycles.
module bit_and_load_store_exec
    import bls_pkg::*;
#(
    parameter int DMEM_AW = 10,
    parameter int IO_REGS = 32
) (
    input  wire logic       i_clk,    // Core clock, 125 MHz.
    input  wire logic       i_nrst,   // Asynchronous reset, active low.
    input  wire logic       i_valid,  // Instruction offered.
    input  wire cmd_t       i_cmd,    // Decoded instruction.
    input  wire logic [7:0] i_addr,   // Register port address.
    input  wire logic [7:0] i_wdata,  // Register port write data.
    input  wire logic       i_wr,     // Register port write strobe.
    input  wire logic       i_rd,     // Register port read strobe.
    output logic      [7:0] o_rdata,  // Read data, cycle after the strobe.
    output logic            o_busy,   // Second cycle of a long instruction.
    output logic            o_done,   // Instruction completed pulse.
    output logic      [7:0] o_status  // Status register.
);

    // ****************************************************************
    // Functions.
    // ****************************************************************
    function automatic logic [4:0] ptr_lo(input ptr_t p);
        case (p)
            ptr_x:   ptr_lo = `BLS_PTR_X_LO;
            ptr_y:   ptr_lo = `BLS_PTR_Y_LO;
            default: ptr_lo = `BLS_PTR_Z_LO;
        endcase
    endfunction : ptr_lo

    function automatic shift_t shift_unit(input op_t op, input logic [7:0] v, input logic c);
        case (op)
            logic_shift_left_op:   shift_unit = '{res: {v[6:0], 1'b0}, c: v[7]};
            logic_shift_right_op:  shift_unit = '{res: {1'b0, v[7:1]}, c: v[0]};
            rotate_left_carry_op:  shift_unit = '{res: {v[6:0], c}, c: v[7]};
            rotate_right_carry_op: shift_unit = '{res: {c, v[7:1]}, c: v[0]};
            arith_shift_right_op:  shift_unit = '{res: {v[7], v[7:1]}, c: v[0]};
            default:               shift_unit = '{res: v, c: c};
        endcase
    endfunction : shift_unit

    function automatic logic [7:0] shift_flags(input shift_t s, input logic [7:0] f);
        logic [7:0] n;
        n = f;
        n[`BLS_FLAG_C] = s.c;
        n[`BLS_FLAG_Z] = (s.res == 8'h00);
        n[`BLS_FLAG_N] = s.res[7];
        n[`BLS_FLAG_V] = s.res[7] ^ s.c;
        n[`BLS_FLAG_S] = s.c;
        return n;
    endfunction : shift_flags

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef enum logic {st_idle, st_second} state_t;

    state_t      state;
    cmd_t        cur;
    logic [7:0]  status_register;
    logic [7:0]  gpr [32];
    logic [7:0]  io_reg [IO_REGS];
    logic [7:0]  mem_rdata;

    // ****************************************************************
    // Decode and datapath.
    // ****************************************************************
    wire op_t         op        = i_cmd.op;
    wire logic        take      = i_valid && (state == st_idle);
    wire logic [7:0]  rd_val    = gpr[i_cmd.rd];
    wire logic [7:0]  rr_val    = gpr[i_cmd.rr];
    wire logic [4:0]  plo       = ptr_lo(i_cmd.ptr);
    wire logic [4:0]  phi       = plo + 5'h01;
    wire logic [15:0] ptr_val   = {gpr[phi], gpr[plo]};
    wire logic        is_load   = (op == indirect_load_op) || (op == offset_load_op)
                                  || (op == absolute_load_op);
    wire logic        is_store  = (op == indirect_store_op) || (op == offset_store_op)
                                  || (op == absolute_store_op);
    wire logic        is_io     = (op == io_bit_set_op) || (op == io_bit_clear_op);
    wire logic        is_ofs    = (op == offset_load_op) || (op == offset_store_op);
    wire logic        bad_ptr   = is_ofs && (i_cmd.ptr == ptr_x);
    wire logic        is_long   = (is_load || is_store || is_io) && !bad_ptr;
    wire logic        is_ind    = (op == indirect_load_op) || (op == indirect_store_op);
    wire logic        ptr_upd   = take && is_ind && (i_cmd.amode != mode_plain);
    wire logic [15:0] ptr_inc   = ptr_val + 16'h0001;
    wire logic [15:0] ptr_dec   = ptr_val - 16'h0001;
    wire logic [15:0] ptr_next  = (i_cmd.amode == mode_pre_dec) ? ptr_dec : ptr_inc;
    wire logic [15:0] ofs_addr  = ptr_val + {10'h000, i_cmd.disp};
    wire logic [15:0] ind_addr  = (i_cmd.amode == mode_pre_dec) ? ptr_dec : ptr_val;
    wire logic [15:0] mem_addr  = (op == absolute_load_op || op == absolute_store_op)
                                  ? i_cmd.addr : (is_ofs ? ofs_addr : ind_addr);
    wire logic        mem_we    = take && is_store && !bad_ptr;
    wire shift_t      sh        = shift_unit(op, rd_val, status_register[`BLS_FLAG_C]);
    wire logic [4:0]  pair_d    = {i_cmd.rd[4:1], 1'b0};
    wire logic [4:0]  pair_r    = {i_cmd.rr[4:1], 1'b0};
    wire logic [4:0]  pair_d1   = {i_cmd.rd[4:1], 1'b1};
    wire logic [4:0]  pair_r1   = {i_cmd.rr[4:1], 1'b1};
    wire logic        io_sel    = (i_addr >= `BLS_IO_BASE) && (i_addr < `BLS_STATUS_ADDR);
    wire logic        gpr_sel   = (i_addr < `BLS_IO_BASE);
    wire logic        st_sel    = (i_addr == `BLS_STATUS_ADDR);
    wire logic [4:0]  bus_idx   = i_addr[4:0];
    wire logic [7:0]  bus_rdata = gpr_sel ? gpr[bus_idx]
                                  : (io_sel ? io_reg[bus_idx]
                                  : (st_sel ? status_register : 8'h00));
    wire logic        fin_long  = (state == st_second);

    bls_data_mem #(
        .AW (DMEM_AW),
        .DW (8)
    ) u_dmem (
        .i_clk   (i_clk),
        .i_we    (mem_we),
        .i_addr  (mem_addr[DMEM_AW-1:0]),
        .i_wdata (rr_val),
        .o_rdata (mem_rdata)
    );

    // Status register next value for one-cycle instructions.
    logic [7:0] next_status;
    always_comb begin
        next_status = status_register;
        if (i_wr && st_sel) begin
            next_status = i_wdata;
        end
        if (take) begin
            case (op)
                logic_shift_left_op, logic_shift_right_op, arith_shift_right_op: begin
                    next_status = shift_flags(sh, status_register);
                end
                rotate_left_carry_op, rotate_right_carry_op: begin
                    next_status = shift_flags(sh, status_register);
                end
                bit_to_transfer_op: next_status[`BLS_FLAG_T] = rr_val[i_cmd.bitsel];
                flag_set_op:        next_status[i_cmd.bitsel] = 1'b1;
                flag_clear_op:      next_status[i_cmd.bitsel] = 1'b0;
                half_carry_set_op:   next_status[`BLS_FLAG_H] = 1'b1;
                half_carry_clear_op: next_status[`BLS_FLAG_H] = 1'b0;
                overflow_set_op:     next_status[`BLS_FLAG_V] = 1'b1;
                overflow_clear_op:   next_status[`BLS_FLAG_V] = 1'b0;
                sign_test_set_op:    next_status[`BLS_FLAG_S] = 1'b1;
                sign_test_clear_op:  next_status[`BLS_FLAG_S] = 1'b0;
                default:             next_status = next_status;
            endcase
        end
    end

    // ****************************************************************
    // Sequencing.
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state  <= st_idle;
            cur    <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            state  <= (take && is_long) ? st_second : st_idle;
            o_busy <= take && is_long;
            o_done <= (take && !is_long) || fin_long;
            if (take) begin
                cur <= i_cmd;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_register <= `BLS_STATUS_RESET;
            o_rdata         <= 8'h00;
        end else begin
            status_register <= next_status;
            o_rdata         <= i_rd ? bus_rdata : 8'h00;
        end
    end

    assign o_status = status_register;

    // I/O registers: the read-modify-write lands on the second cycle.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < IO_REGS; i++) begin
                io_reg[i] <= 8'h00;
            end
        end else begin
            if (i_wr && io_sel) begin
                io_reg[bus_idx] <= i_wdata;
            end
            if (fin_long && cur.op == io_bit_set_op) begin
                io_reg[cur.rr][cur.bitsel] <= 1'b1;
            end
            if (fin_long && cur.op == io_bit_clear_op) begin
                io_reg[cur.rr][cur.bitsel] <= 1'b0;
            end
        end
    end

    // General registers: later assignments win over port writes.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= 8'h00;
            end
        end else begin
            if (i_wr && gpr_sel) begin
                gpr[bus_idx] <= i_wdata;
            end
            if (take) begin
                case (op)
                    logic_shift_left_op, logic_shift_right_op, arith_shift_right_op,
                    rotate_left_carry_op, rotate_right_carry_op: begin
                        gpr[i_cmd.rd] <= sh.res;
                    end
                    nibble_swap_op:     gpr[i_cmd.rd] <= {rd_val[3:0], rd_val[7:4]};
                    transfer_to_bit_op: gpr[i_cmd.rd][i_cmd.bitsel] <= status_register[`BLS_FLAG_T];
                    register_copy_op:   gpr[i_cmd.rd] <= rr_val;
                    immediate_load_op:  gpr[i_cmd.rd] <= i_cmd.imm;
                    register_pair_copy_op: begin
                        gpr[pair_d]  <= gpr[pair_r];
                        gpr[pair_d1] <= gpr[pair_r1];
                    end
                    default: begin
                    end
                endcase
            end
            if (ptr_upd) begin
                gpr[plo] <= ptr_next[7:0];
                gpr[phi] <= ptr_next[15:8];
            end
            if (fin_long && (cur.op == indirect_load_op || cur.op == offset_load_op
                             || cur.op == absolute_load_op)) begin
                gpr[cur.rd] <= mem_rdata;
            end
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    sequence s_two_cycle;
        o_busy && !o_done ##1 !o_busy && o_done;
    endsequence

    sequence s_io_issue(op_t o);
        (take && op == o && !i_wr) ##1 !i_wr;
    endsequence

    property p_io_set;
        @(posedge i_clk) disable iff (!i_nrst)
        s_io_issue(io_bit_set_op) |-> ##1 o_done && io_reg[$past(i_cmd.rr, 2)][$past(i_cmd.bitsel, 2)]
            && status_register == $past(status_register, 2);
    endproperty
    a_io_set: assert property (p_io_set) else $error("I/O bit set failed");

    property p_io_clr;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == io_bit_clear_op && !i_wr) |=> s_two_cycle ##0
            (io_reg[$past(i_cmd.rr, 2)][$past(i_cmd.bitsel, 2)] == 1'b0 || $past(i_wr));
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("I/O bit clear failed");

    property p_rol;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == rotate_left_carry_op && !i_wr) |=> o_done
            && gpr[$past(i_cmd.rd)] == {$past(rd_val[6:0]), $past(status_register[0])}
            && status_register[`BLS_FLAG_C] == $past(rd_val[7]);
    endproperty
    a_rol: assert property (p_rol) else $error("Rotate left wrong");

    property p_ror;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == rotate_right_carry_op && !i_wr) |=> o_done
            && gpr[$past(i_cmd.rd)] == {$past(status_register[0]), $past(rd_val[7:1])}
            && status_register[`BLS_FLAG_C] == $past(rd_val[0]);
    endproperty
    a_ror: assert property (p_ror) else $error("Rotate right wrong");

    property p_bst;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == bit_to_transfer_op && !i_wr) |=>
            status_register[`BLS_FLAG_T] == $past(rr_val[i_cmd.bitsel])
            && ((status_register ^ $past(status_register)) & 8'hBF) == 8'h00;
    endproperty
    a_bst: assert property (p_bst) else $error("Bit store wrong");

    property p_half_set;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == half_carry_set_op && !i_wr) |=> o_done
            && status_register == ($past(status_register) | 8'h20);
    endproperty
    a_half_set: assert property (p_half_set) else $error("Half carry set wrong");

    property p_ovf_clr;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == overflow_clear_op && !i_wr) |=> o_done
            && status_register == ($past(status_register) & 8'hF7);
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("Overflow clear wrong");

    property p_post_inc;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == indirect_load_op && i_cmd.amode == mode_post_inc && !i_wr
         && i_cmd.rd[4:1] != plo[4:1]) |=> s_two_cycle ##0
            {gpr[$past(phi, 2)], gpr[$past(plo, 2)]} == $past(ptr_val, 2) + 16'h0001;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("Post increment wrong");

    property p_pre_dec_st;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == indirect_store_op && i_cmd.amode == mode_pre_dec && !i_wr) |=>
            s_two_cycle;
    endproperty
    a_pre_dec_st: assert property (p_pre_dec_st) else $error("Store length wrong");

    property p_bld;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == transfer_to_bit_op && !i_wr) |=> o_done
            && gpr[$past(i_cmd.rd)][$past(i_cmd.bitsel)] == $past(status_register[`BLS_FLAG_T])
            && ((gpr[$past(i_cmd.rd)] ^ $past(rd_val))
                & ~(8'h01 << $past(i_cmd.bitsel))) == 8'h00
            && status_register == $past(status_register);
    endproperty
    a_bld: assert property (p_bld) else $error("Bit load wrong");

    property p_swap;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == nibble_swap_op && !i_wr) |=> o_done
            && gpr[$past(i_cmd.rd)] == {$past(rd_val[3:0]), $past(rd_val[7:4])}
            && status_register == $past(status_register);
    endproperty
    a_swap: assert property (p_swap) else $error("Nibble swap wrong");

    property p_ofs_ld;
        @(posedge i_clk) disable iff (!i_nrst)
        (take && op == offset_load_op && i_cmd.ptr != ptr_x && !i_wr
         && i_cmd.rd[4:1] != plo[4:1]) |=> s_two_cycle ##0
            {gpr[$past(phi, 2)], gpr[$past(plo, 2)]} == $past(ptr_val, 2);
    endproperty
    a_ofs_ld: assert property (p_ofs_ld) else $error("Displacement load moved pointer");

endmodule : bit_and_load_store_exec

// [verification/regport_host.sv]
`timescale 1ns/1ps

// ****************************************************************
// Register port master standing in for the core register file side.
// ****************************************************************
module regport_host (
    input  wire logic       i_clk,   // Core clock.
    input  wire logic [7:0] i_rdata, // Read data from the block.
    output logic      [7:0] o_addr,  // Port address.
    output logic      [7:0] o_wdata, // Port write data.
    output logic            o_wr,    // Write strobe.
    output logic            o_rd     // Read strobe.
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask : read_reg
endmodule : regport_host

// [verification/bit_and_load_store_exec_tb.sv]
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the bit and transfer execution block.
// ****************************************************************
module bit_and_load_store_exec_tb;
    import bls_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_nrst = 1'b0;
    logic       i_valid = 1'b0;
    cmd_t       i_cmd = '0;
    logic [7:0] i_addr, i_wdata, o_rdata, o_status;
    logic       i_wr, i_rd, o_busy, o_done;
    int         error_cnt = 0;
    int         checked = 0;
    cmd_t       c;

    always #4 i_clk = ~i_clk;

    bit_and_load_store_exec DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
        .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_busy(o_busy), .o_done(o_done), .o_status(o_status));
    regport_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

    task automatic wrap_up();
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        chk(d, e);
    endtask : rd_chk

    // Offers one instruction and checks busy and done against its length.
    task automatic exec(input cmd_t cm, input int n);
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_cmd   <= cm;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        if (n == 2) begin
            chk({o_busy, o_done}, 2'b10);
            @(posedge i_clk);
            #1;
        end
        chk({o_busy, o_done}, 2'b01);
    endtask : exec

    function automatic cmd_t mk(op_t op, logic [4:0] rd, logic [4:0] rr, logic [2:0] b);
        mk        = '0;
        mk.op     = op;
        mk.rd     = rd;
        mk.rr     = rr;
        mk.bitsel = b;
    endfunction : mk

    function automatic logic [7:0] fl(logic [7:0] s, logic [7:0] r, logic cy);
        fl    = s;
        fl[0] = cy;
        fl[1] = (r == 8'h00);
        fl[2] = r[7];
        fl[3] = r[7] ^ cy;
        fl[4] = cy;
    endfunction : fl

    task automatic io_bits();
        host.write_reg(8'h25, 8'h0F);
        host.write_reg(8'h40, 8'h2A);
        exec(mk(io_bit_set_op, 5'h00, 5'h05, 3'h7), 2);
        rd_chk(8'h25, 8'h8F);
        exec(mk(io_bit_clear_op, 5'h00, 5'h05, 3'h0), 2);
        rd_chk(8'h25, 8'h8E);
        chk(o_status, 8'h2A);
    endtask : io_bits

    task automatic shifts();
        op_t        sop [6] = '{logic_shift_left_op, logic_shift_right_op,
            rotate_left_carry_op, rotate_right_carry_op, arith_shift_right_op, nibble_swap_op};
        logic [7:0] ers [6] = '{8'h02, 8'h40, 8'h03, 8'hC0, 8'hC0, 8'h18};
        for (int i = 0; i < 6; i++) begin
            host.write_reg(8'h01, 8'h81);
            host.write_reg(8'h40, 8'h21);
            exec(mk(sop[i], 5'h01, 5'h00, 3'h0), 1);
            rd_chk(8'h01, ers[i]);
            chk(o_status, (i == 5) ? 8'h21 : fl(8'h21, ers[i], 1'b1));
        end
    endtask : shifts

    task automatic flags();
        op_t        fop [6] = '{half_carry_set_op, half_carry_clear_op, overflow_set_op,
            overflow_clear_op, sign_test_set_op, sign_test_clear_op};
        int         pos [6] = '{5, 5, 3, 3, 4, 4};
        logic [7:0] e = 8'h87;
        host.write_reg(8'h40, e);
        for (int i = 0; i < 6; i++) begin
            e[pos[i]] = (i % 2 == 0);
            exec(mk(fop[i], 5'h00, 5'h00, 3'h0), 1);
            chk(o_status, e);
        end
        exec(mk(flag_set_op, 5'h00, 5'h00, 3'h4), 1);
        chk(o_status, 8'h97);
        exec(mk(flag_clear_op, 5'h00, 5'h00, 3'h4), 1);
        chk(o_status, 8'h87);
    endtask : flags

    task automatic bit_moves();
        host.write_reg(8'h40, 8'h00);
        host.write_reg(8'h02, 8'h04);
        host.write_reg(8'h03, 8'h81);
        exec(mk(bit_to_transfer_op, 5'h00, 5'h02, 3'h2), 1);
        chk(o_status, 8'h40);
        exec(mk(transfer_to_bit_op, 5'h03, 5'h00, 3'h5), 1);
        rd_chk(8'h03, 8'hA1);
        c     = mk(immediate_load_op, 5'h08, 5'h00, 3'h0);
        c.imm = 8'h3C;
        exec(c, 1);
        exec(mk(register_copy_op, 5'h09, 5'h08, 3'h0), 1);
        exec(mk(register_pair_copy_op, 5'h0A, 5'h08, 3'h0), 1);
        rd_chk(8'h09, 8'h3C);
        rd_chk(8'h0B, 8'h3C);
        chk(o_status, 8'h40);
    endtask : bit_moves

    task automatic ptr_op(input op_t op, input logic [4:0] r, input ptr_t p, input amode_t m);
        c       = mk(op, r, r, 3'h0);
        c.ptr   = p;
        c.amode = m;
        c.disp  = 6'h04;
        c.addr  = 16'h0010;
        exec(c, 2);
    endtask : ptr_op

    task automatic mem_ops();
        host.write_reg(8'h40, 8'h55);
        host.write_reg(8'h1A, 8'h10);
        host.write_reg(8'h1B, 8'h00);
        host.write_reg(8'h1C, 8'h0C);
        host.write_reg(8'h1D, 8'h00);
        host.write_reg(8'h04, 8'hA5);
        ptr_op(indirect_store_op, 5'h04, ptr_x, mode_post_inc);
        rd_chk(8'h1A, 8'h11);
        ptr_op(indirect_load_op, 5'h05, ptr_x, mode_pre_dec);
        rd_chk(8'h1A, 8'h10);
        rd_chk(8'h05, 8'hA5);
        ptr_op(indirect_load_op, 5'h0C, ptr_x, mode_post_inc);
        rd_chk(8'h0C, 8'hA5);
        rd_chk(8'h1A, 8'h11);
        host.write_reg(8'h06, 8'h5A);
        ptr_op(indirect_store_op, 5'h06, ptr_x, mode_pre_dec);
        rd_chk(8'h1A, 8'h10);
        ptr_op(offset_load_op, 5'h07, ptr_y, mode_plain);
        rd_chk(8'h07, 8'h5A);
        rd_chk(8'h1C, 8'h0C);
        ptr_op(absolute_load_op, 5'h0D, ptr_x, mode_plain);
        rd_chk(8'h0D, 8'h5A);
        host.write_reg(8'h1E, 8'h0E);
        host.write_reg(8'h1F, 8'h00);
        ptr_op(offset_store_op, 5'h04, ptr_z, mode_plain);
        ptr_op(offset_load_op, 5'h0E, ptr_z, mode_plain);
        rd_chk(8'h0E, 8'hA5);
        rd_chk(8'h1E, 8'h0E);
        ptr_op(absolute_store_op, 5'h04, ptr_x, mode_plain);
        ptr_op(absolute_load_op, 5'h0F, ptr_x, mode_plain);
        rd_chk(8'h0F, 8'hA5);
        c.op  = offset_load_op;
        c.ptr = ptr_x;
        exec(c, 1);
        rd_chk(8'h0F, 8'hA5);
        chk(o_status, 8'h55);
    endtask : mem_ops

    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        chk(o_status, 8'h00);
        host.write_reg(8'h41, 8'hFF);
        rd_chk(8'h41, 8'h00);
        io_bits();
        shifts();
        flags();
        bit_moves();
        mem_ops();
        wrap_up();
    end
endmodule : bit_and_load_store_exec_tb
